//--- hdl/wake_sleep_pkg.sv
/*
 * Package for the wake/sleep and boot status block: register offsets,
 * field positions, reset values, timing counts and shared types.
 * Assumes a 32-bit APB slave with one register per aligned word.
 */
package wake_sleep_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] INT_STATUS_OFF = 8'h00;
  localparam logic [7:0] SYSTEM_MODE_OFF = 8'h04;
  localparam logic [7:0] INACTIVITY_COUNT_OFF = 8'h08;
  localparam logic [7:0] SENSOR_CONFIG_OFF = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h10;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h14;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h18;
  localparam logic [7:0] EVENT_IN_OFF = 8'h1C;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BOOT_DONE_BIT = 0;
  localparam int WAKE_SLEEP_BIT = 1;
  localparam int CFG_WAKE_PWR_LSB = 0;
  localparam int CFG_SLEEP_PWR_LSB = 2;
  localparam int CFG_WAKE_RATE_LSB = 4;
  localparam int CFG_SLEEP_RATE_LSB = 8;
  localparam int CFG_FLEX_BIT = 12;
  localparam int CFG_IRQ_EN_BIT = 13;
  localparam int CFG_WAKE_DEC_LSB = 16;
  localparam int CFG_SLEEP_DEC_LSB = 24;
  localparam int IRQ_EV_BOOT = 0;
  localparam int IRQ_EV_WAKE_SLEEP = 1;
  localparam int IRQ_EV_MODE_SLEEP = 2;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [31:0] SENSOR_CONFIG_RST = 32'h0000_0000;
  localparam logic [15:0] INACTIVITY_COUNT_RST = 16'h0000;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;
  localparam logic [7:0] EVENT_MASK_RST = 8'hFF;
  localparam int BOOT_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int ODR_DIV_DEFAULT = 16;

  typedef enum logic [1:0] {BOOTING, WAKE, SLEEP} mode_e;

  typedef struct packed {
    logic [1:0] power;
    logic [3:0] rate;
    logic [7:0] decimation;
    logic flexible;
  } op_point_s;

endpackage : wake_sleep_pkg

//--- hdl/auto_wake_sleep_boot_status.sv
/*
 * Auto wake/sleep and boot status logic of a motion sensor, reached
 * over APB. Assumes pready may be sampled combinationally and that the
 * configured interrupt events arrive as levels on the device clock.
 */
// Local design decisions: the APB slave port and the register offsets.
// Contract
// (R1) The wake/sleep change flag, status bit 1, sets on every switch between wake and sleep and reads 0 otherwise.
// (R2) The system mode register shows whether the device is currently awake or asleep.
// (R3) Sleep is entered after the programmed count of data-rate periods passes with no configured event.
// (R4) Entering sleep applies the sleep power and rate, or sleep decimation in flexible mode.
// (R5) A configured event while asleep returns to wake with the wake power and rate or decimation.
// (R6) Any read of the system mode register clears the wake/sleep change flag.
// (R7) The wake/sleep function and its flag run only while the inactivity count is at least 1.
// (R8) The wake/sleep change flag operates only while its interrupt enable bit is 1.
// (R9) The boot-complete flag, status bit 0, stays 0 while boot runs.
// (R10) The boot-complete flag sets when boot ends, after which commands are accepted.
// (R11) The boot-complete flag stays set until a reset, soft reset or deep power-down exit.
// (R12) Until boot completes every register access fails.
// (R13) Any configured event while awake restarts the inactivity counter.
`timescale 1ns/1ns
`default_nettype none
module auto_wake_sleep_boot_status
  import wake_sleep_pkg::*;
#(
  parameter int ODR_DIV = ODR_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic hibernateExit,
  input wire logic [7:0] eventFlags,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] powerSetting,
  output logic [3:0] dataRate,
  output logic [7:0] decimation,
  output logic flexibleMode,
  output logic irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mode_e mode_q, mode_d;
  logic [15:0] bootCnt_q, bootCnt_d;
  logic [15:0] odrCnt_q, odrCnt_d;
  logic [15:0] idleCnt_q, idleCnt_d;
  logic bootDone_q, bootDone_d;
  logic wakeSleepFlag_q, wakeSleepFlag_d;
  logic [15:0] inactCount_q, inactCount_d;
  logic [31:0] config_q, config_d;
  logic [7:0] eventMask_q, eventMask_d;
  logic [2:0] irqStatus_q, irqStatus_d;
  logic [2:0] irqEnable_q, irqEnable_d;
  logic [31:0] prdata_q, prdata_d;
  logic [1:0] power_q, power_d;
  logic [3:0] rate_q, rate_d;
  logic [7:0] dec_q, dec_d;
  logic flex_q, flex_d;

  logic access, wr, rd, odrTick, anyEvent, autoOn, toSleep, toWake, mdRead;
  logic mapped, rdSetup;
  logic [2:0] irqEvents;
  op_point_s wakePt, sleepPt;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[7:0] == off) && (a[31:8] == 24'h00_0000);
  endfunction : hit

  assign wakePt = '{power: config_q[CFG_WAKE_PWR_LSB +: 2],
                    rate: config_q[CFG_WAKE_RATE_LSB +: 4],
                    decimation: config_q[CFG_WAKE_DEC_LSB +: 8],
                    flexible: config_q[CFG_FLEX_BIT]};
  assign sleepPt = '{power: config_q[CFG_SLEEP_PWR_LSB +: 2],
                     rate: config_q[CFG_SLEEP_RATE_LSB +: 4],
                     decimation: config_q[CFG_SLEEP_DEC_LSB +: 8],
                     flexible: config_q[CFG_FLEX_BIT]};

  // ----------------------------------------------------------------------
  // apb slave: zero wait states; error before boot or on unmapped address
  // ----------------------------------------------------------------------
  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  always_comb begin
    mapped = hit(paddr, INT_STATUS_OFF) || hit(paddr, SYSTEM_MODE_OFF)
             || hit(paddr, INACTIVITY_COUNT_OFF)
             || hit(paddr, SENSOR_CONFIG_OFF) || hit(paddr, IRQ_STATUS_OFF)
             || hit(paddr, IRQ_CLEAR_OFF) || hit(paddr, IRQ_ENABLE_OFF)
             || hit(paddr, EVENT_IN_OFF);
    pslverr = access && (!bootDone_q || !mapped); // [R12]
    wr = access && pwrite && bootDone_q && mapped; // [R12]
    rd = access && !pwrite && bootDone_q && mapped; // [R12]
    rdSetup = psel && !penable && !pwrite && bootDone_d && mapped; // [R12]
  end
  assign mdRead = rd && hit(paddr, SYSTEM_MODE_OFF);

  // ----------------------------------------------------------------------
  // data-rate timebase and activity detection
  // ----------------------------------------------------------------------
  assign odrTick = (odrCnt_q == 16'(ODR_DIV - 1));
  assign anyEvent = |(eventFlags & eventMask_q);
  assign autoOn = (inactCount_q != 16'h0000); // [R7]
  assign toSleep = (mode_q == WAKE) && autoOn && !anyEvent && odrTick
                   && (idleCnt_q + 16'h0001 >= inactCount_q); // [R3]
  assign toWake = (mode_q == SLEEP) && anyEvent; // [R5]

  always_comb begin
    mode_d = mode_q;
    bootCnt_d = bootCnt_q;
    bootDone_d = bootDone_q;
    odrCnt_d = odrTick ? 16'h0000 : odrCnt_q + 16'h0001;
    idleCnt_d = idleCnt_q;
    case (mode_q)
      BOOTING: begin
        bootDone_d = 1'b0; // [R9]
        if (bootCnt_q == 16'(BOOT_CYCLES - 1)) begin
          mode_d = WAKE;
          bootDone_d = 1'b1; // [R10]
        end else begin
          bootCnt_d = bootCnt_q + 16'h0001;
        end
      end
      WAKE: begin
        if (anyEvent || !autoOn) begin
          idleCnt_d = 16'h0000; // [R13]
        end else if (toSleep) begin
          mode_d = SLEEP; // [R3]
          idleCnt_d = 16'h0000;
        end else if (odrTick) begin
          idleCnt_d = idleCnt_q + 16'h0001;
        end
      end
      SLEEP: begin
        if (toWake || !autoOn) begin
          mode_d = WAKE; // [R5]
          idleCnt_d = 16'h0000;
        end
      end
      default: mode_d = BOOTING;
    endcase
    // soft reset and deep power-down exit restart boot
    if (softReset || hibernateExit) begin
      mode_d = BOOTING;
      bootCnt_d = 16'h0000;
      bootDone_d = 1'b0; // [R11]
    end
  end

  // ----------------------------------------------------------------------
  // operating point applied to the sensor core
  // ----------------------------------------------------------------------
  always_comb begin
    op_point_s pt;
    pt = (mode_d == SLEEP) ? sleepPt : wakePt; // [R4] [R5]
    power_d = pt.power;
    rate_d = pt.rate;
    dec_d = pt.decimation;
    flex_d = pt.flexible;
  end
  // in flexible mode decimation steers the core and rate is ignored
  assign powerSetting = power_q;
  assign dataRate = rate_q; // [R4]
  assign decimation = dec_q; // [R4]
  assign flexibleMode = flex_q;

  // ----------------------------------------------------------------------
  // registers and flags
  // ----------------------------------------------------------------------
  always_comb begin
    logic modeSwitch;
    modeSwitch = (mode_q == WAKE && mode_d == SLEEP)
                 || (mode_q == SLEEP && mode_d == WAKE);
    inactCount_d = inactCount_q;
    config_d = config_q;
    eventMask_d = eventMask_q;
    irqEnable_d = irqEnable_q;
    wakeSleepFlag_d = wakeSleepFlag_q;
    irqStatus_d = irqStatus_q;
    if (wr) begin
      if (hit(paddr, INACTIVITY_COUNT_OFF)) begin
        inactCount_d = pwdata[15:0];
      end else if (hit(paddr, SENSOR_CONFIG_OFF)) begin
        config_d = pwdata;
      end else if (hit(paddr, IRQ_ENABLE_OFF)) begin
        irqEnable_d = pwdata[2:0];
      end else if (hit(paddr, EVENT_IN_OFF)) begin
        eventMask_d = pwdata[7:0];
      end else if (hit(paddr, IRQ_CLEAR_OFF)) begin
        irqStatus_d = irqStatus_q & ~pwdata[2:0];
      end
    end
    // read clears, but a switch in the same cycle wins
    if (mdRead) begin
      wakeSleepFlag_d = 1'b0; // [R6]
    end
    if (!autoOn || !config_q[CFG_IRQ_EN_BIT]) begin
      wakeSleepFlag_d = 1'b0; // [R7] [R8]
    end else if (modeSwitch) begin
      wakeSleepFlag_d = 1'b1; // [R1]
    end
    irqEvents = 3'h0;
    irqEvents[IRQ_EV_BOOT] = !bootDone_q && bootDone_d;
    irqEvents[IRQ_EV_WAKE_SLEEP] = !wakeSleepFlag_q && wakeSleepFlag_d;
    irqEvents[IRQ_EV_MODE_SLEEP] = mode_q == WAKE && mode_d == SLEEP;
    irqStatus_d = irqStatus_d | irqEvents;
  end

  assign irq = |(irqStatus_q & irqEnable_q);

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // captured in the setup cycle from the values the registers take at the
  // next edge, so the word stands in flip-flops for the whole access cycle
  // and the host can take it at the edge that samples pready
  always_comb begin
    prdata_d = prdata_q;
    if (rdSetup) begin
      prdata_d = 32'h0000_0000;
      if (hit(paddr, INT_STATUS_OFF)) begin
        prdata_d[BOOT_DONE_BIT] = bootDone_d; // [R10]
        prdata_d[WAKE_SLEEP_BIT] = wakeSleepFlag_d; // [R1]
      end else if (hit(paddr, SYSTEM_MODE_OFF)) begin
        prdata_d[0] = (mode_d == SLEEP); // [R2]
      end else if (hit(paddr, INACTIVITY_COUNT_OFF)) begin
        prdata_d[15:0] = inactCount_d;
      end else if (hit(paddr, SENSOR_CONFIG_OFF)) begin
        prdata_d = config_d;
      end else if (hit(paddr, IRQ_STATUS_OFF)) begin
        prdata_d[2:0] = irqStatus_d;
      end else if (hit(paddr, IRQ_ENABLE_OFF)) begin
        prdata_d[2:0] = irqEnable_d;
      end else if (hit(paddr, EVENT_IN_OFF)) begin
        prdata_d[7:0] = eventMask_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------------
  // soft reset keeps the user configuration; only boot restarts
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= BOOTING;
      bootCnt_q <= 16'h0000;
      bootDone_q <= 1'b0; // [R11]
      odrCnt_q <= 16'h0000;
      idleCnt_q <= 16'h0000;
    end else begin
      mode_q <= mode_d;
      bootCnt_q <= bootCnt_d;
      bootDone_q <= bootDone_d;
      odrCnt_q <= odrCnt_d;
      idleCnt_q <= idleCnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wakeSleepFlag_q <= 1'b0;
      inactCount_q <= INACTIVITY_COUNT_RST;
      config_q <= SENSOR_CONFIG_RST;
      eventMask_q <= EVENT_MASK_RST;
      irqStatus_q <= 3'h0;
      irqEnable_q <= IRQ_ENABLE_RST;
    end else begin
      wakeSleepFlag_q <= wakeSleepFlag_d;
      inactCount_q <= inactCount_d;
      config_q <= config_d;
      eventMask_q <= eventMask_d;
      irqStatus_q <= irqStatus_d;
      irqEnable_q <= irqEnable_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_q <= 2'h0;
      rate_q <= 4'h0;
      dec_q <= 8'h00;
      flex_q <= 1'b0;
    end else begin
      power_q <= power_d;
      rate_q <= rate_d;
      dec_q <= dec_d;
      flex_q <= flex_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

endmodule : auto_wake_sleep_boot_status
`default_nettype wire

//--- sim/wake_sleep_chk.sv
/* assertion checker for the wake/sleep status block, bound to its top;
   assumes only the top module's ports and the package constants */
`timescale 1ns/1ns
`default_nettype none
module wake_sleep_chk
  import wake_sleep_pkg::*;
#(
  parameter int ODR_DIV = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic hibernateExit,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  logic [7:0] bootCnt_q, bootCnt_d;
  logic irqEn_q, irqEn_d, zero_q, zero_d, wrOk;
  // shadow of the config enable bit and the inactivity count that gate the change flag
  always_comb begin
    wrOk = psel && penable && pwrite && !pslverr;
    bootCnt_d = bootCnt_q;
    irqEn_d = irqEn_q;
    zero_d = zero_q;
    if (bootCnt_q < 8'(BOOT_CYCLES + 8))
      bootCnt_d = bootCnt_q + 8'h01;
    if (rst || softReset || hibernateExit)
      bootCnt_d = 8'h00;
    if (wrOk && paddr == {24'h0, SENSOR_CONFIG_OFF})
      irqEn_d = pwdata[CFG_IRQ_EN_BIT];
    if (wrOk && paddr == {24'h0, INACTIVITY_COUNT_OFF})
      zero_d = pwdata[15:0] == 16'h0000;
    if (rst) begin
      irqEn_d = 1'b0;
      zero_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    bootCnt_q <= bootCnt_d;
    irqEn_q <= irqEn_d;
    zero_q <= zero_d;
  end
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence acc;
    psel && penable;
  endsequence
  sequence statusRd;
    acc ##0 !pwrite && paddr == {24'h0, INT_STATUS_OFF};
  endsequence
  a_ready_access: assert property (acc |-> pready)
    else $error("pready low in access");
  a_err_outside: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (acc ##0 paddr[31:8] != 24'h0 |-> pslverr)
    else $error("unmapped access accepted");
  a_err_booting: assert property (
    acc ##0 int'(bootCnt_q) < BOOT_CYCLES - 2 |-> pslverr)
    else $error("access accepted during boot");
  a_ready_booted: assert property (
    statusRd ##0 int'(bootCnt_q) > BOOT_CYCLES + 2 |-> !pslverr)
    else $error("read refused after boot");
  a_boot_flag: assert property (
    statusRd ##0 !pslverr |=> prdata[BOOT_DONE_BIT])
    else $error("boot flag low on accepted read");
  a_flag_disabled: assert property (
    statusRd ##0 !pslverr && (!irqEn_q || zero_q) |=> !prdata[WAKE_SLEEP_BIT])
    else $error("change flag set while disabled");
  a_irq_masked: assert property (acc ##0 wrOk && pwdata[2:0] == 3'h0
    && paddr == {24'h0, IRQ_ENABLE_OFF} |-> ##2 !irq)
    else $error("irq high with all sources masked");
endmodule : wake_sleep_chk
bind auto_wake_sleep_boot_status wake_sleep_chk #(.ODR_DIV(ODR_DIV)) chk_i (
  .clk(clk), .rst(rst), .softReset(softReset), .hibernateExit(hibernateExit),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq)
);
`default_nettype wire

//--- sim/host_model.sv
/* host processor model: apb master tasks called by the bench;
   assumes response and read data stand at the edge that samples pready */
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output var logic psel = 1'b0,
  output var logic penable = 1'b0,
  output var logic pwrite = 1'b0,
  output var logic [31:0] paddr = 32'h0000_0000,
  output var logic [31:0] pwdata = 32'h0000_0000
);
  task automatic access(input logic wr, input logic [31:0] addr,
      input logic [31:0] wdata, output logic [31:0] rdata, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    // response and read data are taken at the pready edge, then released
    err = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : access
  // refused reads are expected until boot ends, so only poll
  task automatic wait_boot();
    logic [31:0] d;
    logic e;
    int n;
    n = 0;
    do begin
      access(1'b0, 32'h0000_0000, 32'h0000_0000, d, e);
      n++;
    end while (e !== 1'b0 && n < 300);
  endtask : wait_boot
endmodule : host_model
`default_nettype wire

//--- sim/testbench.sv
/* self-checking bench for the wake/sleep and boot status block;
   assumes the host model drives the apb side */
`timescale 1ns/1ns
`default_nettype none
module testbench
  import wake_sleep_pkg::*;
;
  localparam int DIV = 2;
  logic clk = 1'b0, rst = 1'b1, softReset = 1'b0, hibernateExit = 1'b0;
  logic [7:0] eventFlags = 8'h00;
  logic psel, penable, pwrite, pready, pslverr, irq, flexibleMode, err;
  logic [31:0] paddr, pwdata, prdata, rd, cfg;
  logic [31:0] seed = 32'hE96766BB;
  logic [1:0] powerSetting;
  logic [3:0] dataRate;
  logic [7:0] decimation;
  logic [7:0] offs [4] = '{INACTIVITY_COUNT_OFF, SENSOR_CONFIG_OFF,
    IRQ_ENABLE_OFF, EVENT_IN_OFF};
  logic [31:0] rstv [4] = '{32'h0, 32'h0, 32'h0, 32'hFF};
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #4 clk = ~clk;
  auto_wake_sleep_boot_status #(.ODR_DIV(DIV)) auto_wake_sleep_boot_status_i (
    .clk(clk), .rst(rst), .softReset(softReset), .eventFlags(eventFlags),
    .hibernateExit(hibernateExit), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerSetting(powerSetting),
    .dataRate(dataRate), .decimation(decimation),
    .flexibleMode(flexibleMode), .irq(irq));
  host_model host_model_i (.clk(clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    host_model_i.access(wr, {24'h0, a}, d, rd, err);
  endtask : rw
  task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
    rw(1'b0, INT_STATUS_OFF, 32'h0);
    check(rd & mask, exp);
  endtask : stat
  // mode read plus the operating point the model expects for that mode
  task automatic mode(input logic [31:0] s);
    rw(1'b0, SYSTEM_MODE_OFF, 32'h0);
    check(rd & 32'h1, s);
    check(32'(flexibleMode), 32'(cfg[CFG_FLEX_BIT]));
    if (cfg[CFG_FLEX_BIT])
      check(32'(decimation), 32'(s[0] ? cfg[31:24] : cfg[23:16]));
    else
      check(32'({powerSetting, dataRate}), s[0] ? 32'({cfg[3:2], cfg[11:8]})
        : 32'({cfg[1:0], cfg[7:4]}));
  endtask : mode
  task automatic irqStep(input logic [7:0] a, input logic [31:0] d, input int e);
    rw(1'b1, a, d);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'(e));
  endtask : irqStep
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      test_done();
    end
  end
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rw(1'b0, INT_STATUS_OFF, 32'h0);
    check(32'(err), 32'h1);
    host_model_i.wait_boot();
    stat(32'h3, 32'h1);
    foreach (offs[i]) begin
      rw(1'b0, offs[i], 32'h0);
      check(rd, rstv[i]);
    end
    host_model_i.access(1'b0, 32'h0000_0100, 32'h0, rd, err);
    check(32'(err), 32'h1);
    $display("boot and reset values done");
    for (int f = 0; f < 2; f++) begin
      cfg = rnd();
      cfg[CFG_FLEX_BIT] = f[0];
      cfg[CFG_IRQ_EN_BIT] = 1'b1;
      eventFlags <= 8'h01;
      rw(1'b1, SENSOR_CONFIG_OFF, cfg);
      rw(1'b1, INACTIVITY_COUNT_OFF, 32'h3);
      repeat (6) begin
        eventFlags <= 8'h00;
        repeat (DIV * 2) @(posedge clk);
        eventFlags <= 8'(rnd()) | 8'h01;
        @(posedge clk);
      end
      eventFlags <= 8'h00;
      mode(32'h0);
      repeat (4 * DIV + 4) @(posedge clk);
      stat(32'h2, 32'h2);
      mode(32'h1);
      stat(32'h2, 32'h0);
      eventFlags <= 8'(rnd()) | 8'h01;
      repeat (2) @(posedge clk);
      stat(32'h2, 32'h2);
      mode(32'h0);
      $display("sleep and wake test done");
    end
    cfg[CFG_IRQ_EN_BIT] = 1'b0;
    rw(1'b1, SENSOR_CONFIG_OFF, cfg);
    eventFlags <= 8'h00;
    repeat (12) @(posedge clk);
    stat(32'h2, 32'h0);
    cfg[CFG_IRQ_EN_BIT] = 1'b1;
    rw(1'b1, SENSOR_CONFIG_OFF, cfg);
    rw(1'b1, INACTIVITY_COUNT_OFF, 32'h0);
    repeat (12) @(posedge clk);
    stat(32'h2, 32'h0);
    mode(32'h0);
    irqStep(IRQ_ENABLE_OFF, 32'h1, 1);
    irqStep(IRQ_ENABLE_OFF, 32'h0, 0);
    irqStep(IRQ_ENABLE_OFF, 32'h1, 1);
    irqStep(IRQ_CLEAR_OFF, 32'h7, 0);
    $display("interrupt test done");
    for (int k = 0; k < 2; k++) begin
      softReset <= (k == 0);
      hibernateExit <= (k == 1);
      @(posedge clk);
      softReset <= 1'b0;
      hibernateExit <= 1'b0;
      rw(1'b0, INT_STATUS_OFF, 32'h0);
      check(32'(err), 32'h1);
      host_model_i.wait_boot();
      stat(32'h1, 32'h1);
      rw(1'b0, SENSOR_CONFIG_OFF, 32'h0);
      check(rd, cfg);
    end
    $display("boot restart test done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
